// File: rtl/fpsf_pkg.sv
// Constants and carrier types for the dual fan PWM controller core.
// Assumes a single 50 MHz system clock; analog front end delivers digital levels.
package fpsf_pkg;

	// System clock rate in Hz
	localparam int CLOCK_HZ = 50_000_000;

	// PWM frequency: typical value and permitted range, in Hz
	localparam int PWM_HZ_TYP = 30;
	localparam int PWM_HZ_MIN = 15;
	localparam int PWM_HZ_MAX = 35;

	// One PWM period is split into slots; duty steps are whole slots
	localparam int             PWM_SLOTS       = 150;
	localparam logic [7:0]     SLOT_LAST       = 8'h95;
	localparam logic [7:0]     DUTY_BASE_SLOTS = 8'h2D;
	localparam logic [7:0]     DUTY_STEP_SLOTS = 8'h07;

	// Forced full-duty start interval, in seconds
	localparam int START_TIME_S = 1;
	localparam int START_CYCLES = CLOCK_HZ * START_TIME_S;

	// Speed measurement window, in seconds
	localparam int WINDOW_TIME_S = 1;
	localparam int WINDOW_CYCLES = CLOCK_HZ * WINDOW_TIME_S;

	// Duty codes
	localparam logic [3:0] DUTY_OPEN_CODE  = 4'h2;
	localparam logic [3:0] DUTY_RESET_CODE = 4'h2;

	// Speed counts and thresholds
	localparam int          SPEED_W      = 16;
	localparam logic [15:0] SPEED_MAX    = 16'hFFFF;
	localparam logic [15:0] THRESH_RESET = 16'h0010;

	// Configuration register layout: bit 5 duty source, bit 0 shutdown
	typedef struct packed {
		logic [1:0] reserved_hi;
		logic       duty_source_select;
		logic [3:0] reserved_lo;
		logic       shutdown_request;
	} fpsf_cfg_t;

	// Status register layout: bit 5 over-temperature, bits 1..0 fan faults
	typedef struct packed {
		logic [1:0] reserved_hi;
		logic       overtemp_flag;
		logic [2:0] reserved_lo;
		logic       fan_two_fault;
		logic       fan_one_fault;
	} fpsf_status_t;

	// Temperature input as digitised by the analog front end
	typedef struct packed {
		logic [3:0] duty_level;
		logic       open;
		logic       over;
	} fpsf_temp_t;

	typedef enum {
		FPSF_OFF,
		FPSF_START,
		FPSF_RUN
	} fpsf_state_t;

endpackage

// File: rtl/fpsf_core.sv
// Fan PWM core: start-up boost, duty selection, two speed monitors, alarm.
// Assumes register storage outside except duty, thresholds and speed counts, held here;
// temperature levels come from on-chip logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Pull alarm low when any fan speed falls below its threshold.
// - In alarm-on-overtemp variant, hold alarm low during over-temperature.
// - Set overtemp flag, status bit 5, whenever temperature input is over threshold.
// - Count qualified pulses per sense input; each count gives that fan's speed.
// - PWM drive is active high.
// - Fixed-frequency PWM with duty limited between 30% and 100%.
// - At 100% duty the drive stays high all period.
// - Period is a parameter, typically 30 Hz.
// - Force 100% duty for one second after power-up or shutdown release.
// - After start-up pick duty source from config bit 5; analog by default.
// - Analog source with temperature input open gives 39.33% duty.
// - PWM frequency parameter restricted to 15 Hz to 35 Hz.
// - Speed data readable; thresholds readable and writable.
// - Config bit 5 set selects duty register; clear selects analog input.
// - Four-bit duty register, code 0 is 30%, code 15 is 100%.
// - Drive keeps pulsing after fan fault; stops only on shutdown bit 0.
module fpsf_core #(
	parameter int CLK_HZ        = fpsf_pkg::CLOCK_HZ,
	parameter int PWM_HZ        = fpsf_pkg::PWM_HZ_TYP,
	parameter int START_CYCLES  = fpsf_pkg::START_CYCLES,
	parameter int WINDOW_CYCLES = fpsf_pkg::WINDOW_CYCLES
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_nrst,
	input  wire logic                   i_fan_one_pulse_in,
	input  wire logic                   i_fan_two_pulse_in,
	input  wire fpsf_pkg::fpsf_temp_t   i_temp_voltage_in,
	input  wire fpsf_pkg::fpsf_cfg_t    i_config,
	input  wire logic                   i_overtemp_alarm_en,
	input  wire logic                   i_duty_wr,
	input  wire logic [3:0]             i_duty_wdata,
	input  wire logic [1:0]             i_thresh_wr,
	input  wire logic [15:0]            i_thresh_wdata,
	input  wire logic                   i_alarm_in,
	output logic                        o_pwm_drive_out,
	output logic                        o_alarm_out,
	output logic                        o_alarm_oe,
	output logic                        o_alarm_line_low,
	output fpsf_pkg::fpsf_status_t      o_status,
	output logic [3:0]                  o_duty_code,
	output logic [15:0]                 o_fan_one_speed,
	output logic [15:0]                 o_fan_two_speed,
	output logic [15:0]                 o_fan_one_thresh,
	output logic [15:0]                 o_fan_two_thresh,
	output logic                        o_startup_active
);

	// Out-of-range frequencies are clamped rather than rejected
	localparam int EFF_HZ = (PWM_HZ < fpsf_pkg::PWM_HZ_MIN) ? fpsf_pkg::PWM_HZ_MIN :
		(PWM_HZ > fpsf_pkg::PWM_HZ_MAX) ? fpsf_pkg::PWM_HZ_MAX : PWM_HZ;
	localparam int SLOT_RAW    = CLK_HZ / (EFF_HZ * fpsf_pkg::PWM_SLOTS);
	localparam int SLOT_CYCLES = (SLOT_RAW < 1) ? 1 : SLOT_RAW;
	localparam int START_EFF   = (START_CYCLES < 1) ? 1 : START_CYCLES;
	localparam int WINDOW_EFF  = (WINDOW_CYCLES < 1) ? 1 : WINDOW_CYCLES;

	localparam logic [31:0] SLOT_END   = 32'(SLOT_CYCLES - 1);
	localparam logic [31:0] START_END  = 32'(START_EFF - 1);
	localparam logic [31:0] WINDOW_END = 32'(WINDOW_EFF - 1);

	// Number of high slots for a duty code
	function automatic logic [7:0] on_slots(input logic [3:0] code);
		on_slots = fpsf_pkg::DUTY_BASE_SLOTS + 8'(code) * fpsf_pkg::DUTY_STEP_SLOTS;
	endfunction

	fpsf_pkg::fpsf_state_t state;
	fpsf_pkg::fpsf_state_t next_state;

	logic [31:0] start_cnt;
	logic [31:0] slot_div;
	logic        slot_tick;
	logic [7:0]  slot;
	logic [3:0]  duty_reg;
	logic [3:0]  active_code;
	logic        next_pwm;
	logic [31:0] win_cnt;
	logic        win_end;
	logic [1:0]  pulse_raw;
	logic [1:0]  pulse_meta;
	logic [1:0]  pulse_sync;
	logic [1:0]  pulse_prev;
	logic [1:0]  pulse_edge;
	logic [1:0]  fault;
	logic [15:0] speed   [2];
	logic [15:0] thresh  [2];
	logic [15:0] pulses  [2];
	logic        overtemp;
	logic        alarm;
	logic        alarm_meta;
	logic        alarm_sync;

	assign pulse_raw = {i_fan_two_pulse_in, i_fan_one_pulse_in};

	// Sequencing: shutdown has priority; its release restarts the boost
	always_comb begin
		next_state = state;
		case (state)
			fpsf_pkg::FPSF_OFF: begin
				if (!i_config.shutdown_request) begin
					next_state = fpsf_pkg::FPSF_START;
				end
			end
			fpsf_pkg::FPSF_START: begin
				if (i_config.shutdown_request) begin
					next_state = fpsf_pkg::FPSF_OFF;
				end else if (start_cnt == START_END) begin
					next_state = fpsf_pkg::FPSF_RUN;
				end
			end
			fpsf_pkg::FPSF_RUN: begin
				if (i_config.shutdown_request) begin
					next_state = fpsf_pkg::FPSF_OFF;
				end
			end
			default: begin
				next_state = fpsf_pkg::FPSF_START;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= fpsf_pkg::FPSF_START;
		end else begin
			state <= next_state;
		end
	end

	// Boost interval timer
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			start_cnt <= 32'h00000000;
		end else if (state != fpsf_pkg::FPSF_START) begin
			start_cnt <= 32'h00000000;
		end else if (start_cnt != START_END) begin
			start_cnt <= start_cnt + 32'h00000001;
		end
	end

	// Slot divider sets the fixed PWM frequency
	assign slot_tick = (slot_div == SLOT_END);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			slot_div <= 32'h00000000;
		end else if (slot_tick) begin
			slot_div <= 32'h00000000;
		end else begin
			slot_div <= slot_div + 32'h00000001;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			slot <= 8'h00;
		end else if (slot_tick) begin
			if (slot == fpsf_pkg::SLOT_LAST) begin
				slot <= 8'h00;
			end else begin
				slot <= slot + 8'h01;
			end
		end
	end

	// Duty register, written directly by the management side
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			duty_reg <= fpsf_pkg::DUTY_RESET_CODE;
		end else if (i_duty_wr) begin
			duty_reg <= i_duty_wdata;
		end
	end

	// Source can change at any time; the new duty applies from the next clock, even mid-slot
	always_comb begin
		if (i_config.duty_source_select) begin
			active_code = duty_reg;
		end else if (i_temp_voltage_in.open) begin
			active_code = fpsf_pkg::DUTY_OPEN_CODE;
		end else begin
			active_code = i_temp_voltage_in.duty_level;
		end
	end

	// Code 15 gives 150 slots, so the compare never goes false
	always_comb begin
		case (state)
			fpsf_pkg::FPSF_OFF:   next_pwm = 1'b0;
			fpsf_pkg::FPSF_START: next_pwm = 1'b1;
			fpsf_pkg::FPSF_RUN:   next_pwm = (slot < on_slots(active_code));
			default:              next_pwm = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pwm_drive_out <= 1'b0;
		end else begin
			o_pwm_drive_out <= next_pwm;
		end
	end

	// Measurement window shared by both fans
	assign win_end = (win_cnt == WINDOW_END);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			win_cnt <= 32'h00000000;
		end else if (win_end) begin
			win_cnt <= 32'h00000000;
		end else begin
			win_cnt <= win_cnt + 32'h00000001;
		end
	end

	// Per-fan pulse capture, speed latch and fault
	for (genvar f = 0; f < 2; f++) begin : g_fan
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				pulse_meta[f] <= 1'b0;
				pulse_sync[f] <= 1'b0;
				pulse_prev[f] <= 1'b0;
			end else begin
				pulse_meta[f] <= pulse_raw[f];
				pulse_sync[f] <= pulse_meta[f];
				pulse_prev[f] <= pulse_sync[f];
			end
		end

		assign pulse_edge[f] = pulse_sync[f] & ~pulse_prev[f];

		// An edge in the closing cycle starts the next window's count
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				pulses[f] <= 16'h0000;
			end else if (win_end) begin
				pulses[f] <= {15'h0000, pulse_edge[f]};
			end else if (pulse_edge[f] && pulses[f] != fpsf_pkg::SPEED_MAX) begin
				pulses[f] <= pulses[f] + 16'h0001;
			end
		end

		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				speed[f] <= 16'h0000;
			end else if (win_end) begin
				speed[f] <= pulses[f];
			end
		end

		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				thresh[f] <= fpsf_pkg::THRESH_RESET;
			end else if (i_thresh_wr[f]) begin
				thresh[f] <= i_thresh_wdata;
			end
		end

		// A fan stopped by shutdown is not a failure
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				fault[f] <= 1'b0;
			end else if (state == fpsf_pkg::FPSF_OFF) begin
				fault[f] <= 1'b0;
			end else if (win_end) begin
				fault[f] <= (pulses[f] < thresh[f]);
			end
		end
	end

	// Over-temperature follows the comparator level
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			overtemp <= 1'b0;
		end else begin
			overtemp <= i_temp_voltage_in.over;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			alarm <= 1'b0;
		end else begin
			alarm <= (|fault) | (i_overtemp_alarm_en & overtemp);
		end
	end

	// Read-back of the shared alarm wire, another driver may pull it too
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			alarm_meta <= 1'b1;
			alarm_sync <= 1'b1;
		end else begin
			alarm_meta <= i_alarm_in;
			alarm_sync <= alarm_meta;
		end
	end

	// Open drain: only ever drives low
	assign o_alarm_out      = 1'b0;
	assign o_alarm_oe       = alarm;
	assign o_alarm_line_low = ~alarm_sync;

	always_comb begin
		o_status               = '0;
		o_status.overtemp_flag = overtemp;
		o_status.fan_one_fault = fault[0];
		o_status.fan_two_fault = fault[1];
	end

	assign o_duty_code      = duty_reg;
	assign o_fan_one_speed  = speed[0];
	assign o_fan_two_speed  = speed[1];
	assign o_fan_one_thresh = thresh[0];
	assign o_fan_two_thresh = thresh[1];
	assign o_startup_active = (state == fpsf_pkg::FPSF_START);

endmodule

`default_nettype wire

// File: bench/fpsf_check_assertions.sv
// Port-level checker for the fan PWM core.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fpsf_check (
	input wire logic                   i_clock,
	input wire logic                   i_nrst,
	input wire fpsf_pkg::fpsf_temp_t   i_temp_voltage_in,
	input wire fpsf_pkg::fpsf_cfg_t    i_config,
	input wire logic                   i_overtemp_alarm_en,
	input wire logic                   i_duty_wr,
	input wire logic [3:0]             i_duty_wdata,
	input wire logic                   o_pwm_drive_out,
	input wire logic                   o_alarm_oe,
	input wire fpsf_pkg::fpsf_status_t o_status,
	input wire logic [3:0]             o_duty_code,
	input wire logic                   o_startup_active
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	property p_otflag; $stable(i_temp_voltage_in.over)[*3] |->
		o_status.overtemp_flag == i_temp_voltage_in.over; endproperty
	a_otflag: assert property (p_otflag) else $error("overtemp flag wrong");
	property p_otalarm;
		(i_overtemp_alarm_en && i_temp_voltage_in.over)[*3] |-> o_alarm_oe; endproperty
	a_otalarm: assert property (p_otalarm) else $error("no overtemp alarm");
	property p_fltalarm; (|o_status[1:0])[*2] |-> o_alarm_oe; endproperty
	a_fltalarm: assert property (p_fltalarm) else $error("no speed alarm");
	property p_release; (!i_temp_voltage_in.over && !(|o_status[1:0]))[*3] |->
		!o_alarm_oe; endproperty
	a_release: assert property (p_release) else $error("alarm held");
	property p_boost; o_startup_active[*3] |-> o_pwm_drive_out; endproperty
	a_boost: assert property (p_boost) else $error("boost not full");
	property p_shut; i_config.shutdown_request[*4] |->
		!o_pwm_drive_out && !o_startup_active; endproperty
	a_shut: assert property (p_shut) else $error("drive on in shutdown");
	property p_full; (!o_startup_active && i_config.duty_source_select
		&& o_duty_code == 4'hF && !i_config.shutdown_request)[*3] |-> o_pwm_drive_out;
	endproperty
	a_full: assert property (p_full) else $error("full duty has low phase");
	property p_dutywr; i_duty_wr |=> o_duty_code == $past(i_duty_wdata); endproperty
	a_dutywr: assert property (p_dutywr) else $error("duty write lost");
endmodule
bind fpsf_core fpsf_check u_check (.i_clock(i_clock), .i_nrst(i_nrst),
	.i_temp_voltage_in(i_temp_voltage_in), .i_config(i_config),
	.i_overtemp_alarm_en(i_overtemp_alarm_en), .i_duty_wr(i_duty_wr),
	.i_duty_wdata(i_duty_wdata), .o_pwm_drive_out(o_pwm_drive_out),
	.o_alarm_oe(o_alarm_oe), .o_status(o_status), .o_duty_code(o_duty_code),
	.o_startup_active(o_startup_active));
`default_nettype wire

// File: bench/fpsf_fan_model.sv
// Fan plus sense network: one current pulse every i_period clocks.
// Assumes period zero is a locked rotor; the coupled line then idles low.
`timescale 1ns/1ps
`default_nettype none
module fpsf_fan_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_period,
	output logic            o_pulse
);
	logic [7:0] tick;
	initial begin
		tick = 8'h00;
		o_pulse = 1'b0;
	end
	always @(posedge i_clock) begin
		tick <= (tick + 8'h01 >= i_period) ? 8'h00 : tick + 8'h01;
		o_pulse <= (i_period != 8'h00) && (tick == 8'h00);
	end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the fan PWM core with two fan models.
// Assumes shrunk timing: 10-cycle slots, 200-cycle boost, 500-cycle window.
`timescale 1ns/1ps
`default_nettype none
`define FPSF_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
	localparam int WIN = 500;
	logic                   i_clock;
	logic                   i_nrst;
	logic                   ot_en;
	logic                   duty_wr;
	logic                   pwm;
	logic                   oe;
	logic                   alarm_drv;
	logic                   line_low;
	logic                   boost;
	logic                   fan1;
	logic                   fan2;
	logic [1:0]             thr_wr;
	logic [3:0]             duty_wd;
	logic [3:0]             duty_rd;
	logic [3:0]             d;
	logic [7:0]             per1;
	logic [7:0]             per2;
	logic [15:0]            thr_wd;
	logic [15:0]            t1;
	logic [15:0]            spd1;
	logic [15:0]            spd2;
	logic [15:0]            thr1;
	logic [15:0]            thr2;
	fpsf_pkg::fpsf_temp_t   temp;
	fpsf_pkg::fpsf_cfg_t    cfg;
	fpsf_pkg::fpsf_status_t st;
	int                     bad_count;
	int                     samples_checked;
	int                     cycles;
	int                     hi;
	int                     i;
	integer                 seed;
	wire logic              alarm_wire;
	// Board pull-up: the line reads high whenever no one pulls it
	assign alarm_wire = oe ? alarm_drv : 1'b1;

	fpsf_core #(.CLK_HZ(45000), .START_CYCLES(200), .WINDOW_CYCLES(WIN)) dut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_fan_one_pulse_in(fan1),
		.i_fan_two_pulse_in(fan2), .i_temp_voltage_in(temp), .i_config(cfg),
		.i_overtemp_alarm_en(ot_en), .i_duty_wr(duty_wr), .i_duty_wdata(duty_wd),
		.i_thresh_wr(thr_wr), .i_thresh_wdata(thr_wd), .i_alarm_in(alarm_wire),
		.o_pwm_drive_out(pwm), .o_alarm_out(alarm_drv), .o_alarm_oe(oe),
		.o_alarm_line_low(line_low), .o_status(st), .o_duty_code(duty_rd),
		.o_fan_one_speed(spd1), .o_fan_two_speed(spd2), .o_fan_one_thresh(thr1),
		.o_fan_two_thresh(thr2), .o_startup_active(boost));
	fpsf_fan_model fan_a (.i_clock(i_clock), .i_period(per1), .o_pulse(fan1));
	fpsf_fan_model fan_b (.i_clock(i_clock), .i_period(per2), .o_pulse(fan2));

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	task automatic final_report();
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			final_report();
		end
	end

	function automatic int exp_hi(input logic [3:0] c);
		return (int'(fpsf_pkg::DUTY_BASE_SLOTS) + int'(fpsf_pkg::DUTY_STEP_SLOTS) * int'(c)) * 10;
	endfunction

	task automatic count_hi(input int n);
		hi = 0;
		repeat (n) begin
			@(negedge i_clock);
			// An unknown drive level poisons the count so no check can pass
			if (pwm === 1'b1)
				hi++;
			else if (pwm !== 1'b0)
				hi += 100000;
		end
	endtask

	// Any whole period after the settle gap holds the exact high time
	task automatic measure(input logic [3:0] c);
		count_hi(20);
		count_hi(1500);
		`FPSF_CHK("duty", exp_hi(c), hi)
	endtask

	task automatic wr_duty(input logic [3:0] v);
		@(posedge i_clock);
		duty_wr <= 1'b1;
		duty_wd <= v;
		@(posedge i_clock);
		duty_wr <= 1'b0;
	endtask

	task automatic wr_thr(input logic [1:0] sel, input logic [15:0] v);
		@(posedge i_clock);
		thr_wr <= sel;
		thr_wd <= v;
		@(posedge i_clock);
		thr_wr <= 2'h0;
	endtask

	initial begin
		seed = 32'h3AA0;
		bad_count = 0;
		samples_checked = 0;
		i_nrst = 1'b0;
		ot_en = 1'b0;
		duty_wr = 1'b0;
		duty_wd = 4'h0;
		thr_wr = 2'h0;
		thr_wd = 16'h0000;
		per1 = 8'h14;
		per2 = 8'h19;
		temp = '0;
		cfg = '0;
		repeat (3) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(negedge i_clock);
		`FPSF_CHK("duty_rst", fpsf_pkg::DUTY_RESET_CODE, duty_rd)
		`FPSF_CHK("thr_rst", fpsf_pkg::THRESH_RESET, thr2)
		count_hi(150);
		`FPSF_CHK("boost_hi", 150, hi)
		`FPSF_CHK("boost_on", 1'b1, boost)
		count_hi(100);
		`FPSF_CHK("boost_off", 1'b0, boost)
		@(posedge i_clock);
		temp <= '{duty_level: 4'hC, open: 1'b1, over: 1'b0};
		measure(4'h2);
		for (i = 0; i < 3; i++) begin
			d = 4'($random(seed));
			@(posedge i_clock);
			temp <= '{duty_level: d, open: 1'b0, over: 1'b0};
			measure(d);
		end
		@(posedge i_clock);
		cfg.duty_source_select <= 1'b1;
		for (i = 0; i < 5; i++) begin
			d = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
			wr_duty(d);
			@(negedge i_clock);
			`FPSF_CHK("duty_rd", d, duty_rd)
			measure(d);
		end
		t1 = 16'(({$random(seed)} % 25) + 1);
		@(posedge i_clock);
		thr_wr <= 2'h1;
		thr_wd <= t1;
		@(posedge i_clock);
		thr_wr <= 2'h2;
		thr_wd <= 16'(WIN / 25);
		@(posedge i_clock);
		thr_wr <= 2'h0;
		@(negedge i_clock);
		`FPSF_CHK("thr1", t1, thr1)
		`FPSF_CHK("thr2", 16'(WIN / 25), thr2)
		repeat (3 * WIN) @(negedge i_clock);
		`FPSF_CHK("spd1", 16'(WIN / 20), spd1)
		`FPSF_CHK("spd2", 16'(WIN / 25), spd2)
		`FPSF_CHK("faults", 2'h0, st[1:0])
		`FPSF_CHK("line", 1'b0, line_low)
		@(posedge i_clock);
		per2 <= 8'h00;
		repeat (3 * WIN) @(negedge i_clock);
		`FPSF_CHK("spd2", 16'h0000, spd2)
		`FPSF_CHK("faults", 2'h2, st[1:0])
		`FPSF_CHK("line", 1'b1, line_low)
		measure(d);
		@(posedge i_clock);
		per2 <= 8'h19;
		repeat (3 * WIN) @(negedge i_clock);
		`FPSF_CHK("faults", 2'h0, st[1:0])
		`FPSF_CHK("line", 1'b0, line_low)
		// Fan one just under, then exactly at, its threshold
		wr_thr(2'h1, 16'(WIN / 20 + 1));
		repeat (2 * WIN) @(negedge i_clock);
		`FPSF_CHK("faults", 2'h1, st[1:0])
		`FPSF_CHK("line", 1'b1, line_low)
		wr_thr(2'h1, 16'(WIN / 20));
		repeat (2 * WIN) @(negedge i_clock);
		`FPSF_CHK("faults", 2'h0, st[1:0])
		`FPSF_CHK("line", 1'b0, line_low)
		@(posedge i_clock);
		temp.over <= 1'b1;
		repeat (10) @(negedge i_clock);
		`FPSF_CHK("otf", 1'b1, st.overtemp_flag)
		`FPSF_CHK("line", 1'b0, line_low)
		@(posedge i_clock);
		ot_en <= 1'b1;
		repeat (10) @(negedge i_clock);
		`FPSF_CHK("line", 1'b1, line_low)
		@(posedge i_clock);
		temp.over <= 1'b0;
		repeat (10) @(negedge i_clock);
		`FPSF_CHK("otf", 1'b0, st.overtemp_flag)
		`FPSF_CHK("line", 1'b0, line_low)
		@(posedge i_clock);
		cfg.shutdown_request <= 1'b1;
		repeat (5) @(negedge i_clock);
		count_hi(WIN);
		`FPSF_CHK("shut_hi", 0, hi)
		`FPSF_CHK("shut_boost", 1'b0, boost)
		@(posedge i_clock);
		cfg.shutdown_request <= 1'b0;
		count_hi(10);
		`FPSF_CHK("reboost", 1'b1, boost)
		`FPSF_CHK("reboost_pwm", 1'b1, pwm)
		final_report();
	end
endmodule
`default_nettype wire
